// ---- hw/cpc_config_port.sv ----
// Configuration-port pin logic: passive load, active serial read, chain enable
`timescale 1ns/1ps
// How it works
// - Configure only while chip enable low
// - Chain enable driven low after configuration
// - Chain enable pin becomes user I/O
// - Active serial: drive command line to memory
// - Active serial: drive memory select low
// - Passive: capture data on clock rising edge
// - Active serial: device generates config clock
// - After load clock inactive, toggles ignored
// - Serial modes: one bit per clock
// - Parallel mode: one byte per clock
// - Serial schemes: upper data pins tri-stated until user mode, then user I/O
// - Parallel: upper data pins become user I/O
// - First variant: serial data pin dedicated
// - Second variant: serial data pin user I/O, except after active serial
// - Restart low resets, tri-states; high reloads
// - Scheme chosen from static select inputs
module cpc_config_port #(
    parameter bit VARIANT_B = 1'b0,
    parameter int SEL_W = 4,
    parameter int DIV_HALF = cpc_pkg::AS_HALF_CYCLES
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire logic I_CHIP_ENABLE_LOW,
    input wire logic I_CONFIG_RESTART_LOW,
    input wire logic [SEL_W-1:0] I_SCHEME_SELECT,
    input wire logic I_SHARED_PIN_USER,
    input wire logic I_LOAD_DONE,
    input wire logic I_CONFIG_CLOCK,
    output logic O_CONFIG_CLOCK,
    output logic O_CONFIG_CLOCK_OE_N,
    input wire logic [7:0] I_DATA,
    output logic [7:0] O_DATA,
    output logic [7:0] O_DATA_OE_N,
    output logic O_SERIAL_COMMAND_OUT,
    output logic O_MEMORY_SELECT_LOW,
    input wire logic I_CHAIN_ENABLE,
    output logic O_CHAIN_ENABLE,
    output logic O_CHAIN_ENABLE_OE_N,
    input wire logic [8:0] I_USER_OUT,
    input wire logic [8:0] I_USER_OE_N,
    output logic [8:0] O_USER_IN,
    output logic [7:0] O_CFG_BYTE,
    output logic O_CFG_BYTE_VALID,
    output logic O_USER_MODE
);
    localparam int SW = SEL_W + 12;

    initial begin
        if (SEL_W < 2 || SEL_W > 4) $error("cpc_config_port: SEL_W must be 2 to 4");
        // Synchroniser latency must fit inside half a generated clock period
        if (DIV_HALF < 3 || DIV_HALF > 255) $error("cpc_config_port: DIV_HALF out of 3..255");
    end

    logic [SW-1:0] pins_s;
    logic ce_s;
    logic restart_s;
    logic [SEL_W-1:0] scheme_s;
    logic cclk_s;
    logic [7:0] data_s;
    logic chain_s;

    cpc_pin_sync #(.WIDTH(SW)) u_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RST_N),
        .i_async({I_CHIP_ENABLE_LOW, I_CONFIG_RESTART_LOW, I_SCHEME_SELECT, I_CONFIG_CLOCK,
                  I_DATA, I_CHAIN_ENABLE}),
        .o_sync(pins_s)
    );
    assign {ce_s, restart_s, scheme_s, cclk_s, data_s, chain_s} = pins_s;

    cpc_pkg::cpc_state_t state, next_state;
    cpc_pkg::cpc_mode_t mode, next_mode;
    logic prev_cclk, next_prev_cclk;
    logic [7:0] div_cnt, next_div_cnt;
    logic clk_out, next_clk_out;
    logic [31:0] cmd_sr, next_cmd_sr;
    logic [5:0] cmd_cnt, next_cmd_cnt;
    logic cmd_out, next_cmd_out;
    logic sel_low, next_sel_low;
    logic [7:0] shift, next_shift;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] byte_out, next_byte_out;
    logic byte_valid, next_byte_valid;

    logic pas_rise;
    logic tick;
    logic sample;
    logic sample_bit;
    logic [SEL_W-1:0] sel_fpp, sel_ps, sel_as;

    assign sel_fpp = cpc_pkg::SCHEME_FPP[SEL_W-1:0];
    assign sel_ps = cpc_pkg::SCHEME_PS[SEL_W-1:0];
    assign sel_as = cpc_pkg::SCHEME_AS[SEL_W-1:0];
    assign pas_rise = cclk_s & ~prev_cclk;
    assign tick = (div_cnt == 8'(DIV_HALF - 1));

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_prev_cclk = cclk_s;
        next_div_cnt = 8'h00;
        next_clk_out = clk_out;
        next_cmd_sr = cmd_sr;
        next_cmd_cnt = cmd_cnt;
        next_cmd_out = cmd_out;
        next_sel_low = sel_low;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_byte_out = byte_out;
        next_byte_valid = 1'b0;
        sample = 1'b0;
        sample_bit = data_s[0];
        unique case (state)
            cpc_pkg::ST_RESET: begin
                next_clk_out = 1'b0;
                next_sel_low = 1'b1;
                next_bit_cnt = cpc_pkg::BIT_CNT_RST;
                // restart high starts a new load
                if (restart_s) next_state = cpc_pkg::ST_IDLE;
            end
            cpc_pkg::ST_IDLE: begin
                // wait for chip enable; scheme from select pins
                if (!ce_s) begin
                    if (scheme_s == sel_as) begin
                        next_mode = cpc_pkg::MD_AS;
                        next_state = cpc_pkg::ST_COMMAND;
                        next_sel_low = 1'b0;
                        next_cmd_sr = {cpc_pkg::MEM_READ_OPCODE, cpc_pkg::MEM_START_ADDR} << 1;
                        next_cmd_out = cpc_pkg::MEM_READ_OPCODE[7];
                        next_cmd_cnt = 6'h00;
                    end else if (scheme_s == sel_ps) begin
                        next_mode = cpc_pkg::MD_PS;
                        next_state = cpc_pkg::ST_LOAD;
                    end else if (scheme_s == sel_fpp) begin
                        next_mode = cpc_pkg::MD_FPP;
                        next_state = cpc_pkg::ST_LOAD;
                    end
                end
            end
            cpc_pkg::ST_COMMAND: begin
                // generated clock; command shifted out on falling edges
                next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
                if (tick) begin
                    next_clk_out = ~clk_out;
                    if (!clk_out) begin
                        next_cmd_cnt = cmd_cnt + 6'h01;
                    end else if (cmd_cnt == 6'(cpc_pkg::CMD_BITS)) begin
                        next_state = cpc_pkg::ST_LOAD;
                    end else begin
                        next_cmd_out = cmd_sr[31];
                        next_cmd_sr = cmd_sr << 1;
                    end
                end
            end
            cpc_pkg::ST_LOAD: begin
                if (I_LOAD_DONE) begin
                    next_state = cpc_pkg::ST_USER;
                    next_clk_out = 1'b0;
                    next_sel_low = 1'b1;
                end else if (mode == cpc_pkg::MD_AS) begin
                    // Generated clock pauses while chip enable is high
                    if (!ce_s) begin
                        next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
                        if (tick) begin
                            next_clk_out = ~clk_out;
                            sample = ~clk_out;
                        end
                    end else begin
                        next_div_cnt = div_cnt;
                    end
                end else if (mode == cpc_pkg::MD_FPP) begin
                    if (pas_rise && !ce_s) begin
                        next_byte_out = data_s;
                        next_byte_valid = 1'b1;
                    end
                end else begin
                    sample = pas_rise & ~ce_s;
                end
                // one bit per clock, LSB first
                if (sample) begin
                    next_shift = {sample_bit, shift[7:1]};
                    next_bit_cnt = bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7) begin
                        next_byte_out = {sample_bit, shift[7:1]};
                        next_byte_valid = 1'b1;
                    end
                end
            end
            cpc_pkg::ST_USER: begin
                // clock edges no longer reach the load logic
                next_clk_out = 1'b0;
            end
        endcase
        if (!restart_s) next_state = cpc_pkg::ST_RESET;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state <= cpc_pkg::ST_RESET;
            mode <= cpc_pkg::MD_PS;
            prev_cclk <= 1'b0;
            div_cnt <= 8'h00;
            clk_out <= 1'b0;
            cmd_sr <= 32'h00000000;
            cmd_cnt <= 6'h00;
            cmd_out <= 1'b1;
            sel_low <= 1'b1;
            shift <= cpc_pkg::BYTE_RST;
            bit_cnt <= cpc_pkg::BIT_CNT_RST;
            byte_out <= cpc_pkg::BYTE_RST;
            byte_valid <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            prev_cclk <= next_prev_cclk;
            div_cnt <= next_div_cnt;
            clk_out <= next_clk_out;
            cmd_sr <= next_cmd_sr;
            cmd_cnt <= next_cmd_cnt;
            cmd_out <= next_cmd_out;
            sel_low <= next_sel_low;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            byte_out <= next_byte_out;
            byte_valid <= next_byte_valid;
        end
    end

    logic in_user;
    logic as_active;
    logic [7:0] data_user;
    assign in_user = (state == cpc_pkg::ST_USER);
    assign as_active = (mode == cpc_pkg::MD_AS) &&
                       (state == cpc_pkg::ST_COMMAND || state == cpc_pkg::ST_LOAD);
    // serial data pin is user I/O only in the second variant
    assign data_user[0] = VARIANT_B && in_user && (mode != cpc_pkg::MD_AS) && I_SHARED_PIN_USER;
    // upper pins tri-stated until user mode
    assign data_user[7:1] = {7{in_user && (mode != cpc_pkg::MD_FPP || I_SHARED_PIN_USER)}};

    always_comb begin
        // clock driven in active serial, held low after load
        O_CONFIG_CLOCK = clk_out;
        O_CONFIG_CLOCK_OE_N = ~(as_active || (in_user && mode == cpc_pkg::MD_AS));
        O_DATA = I_USER_OUT[7:0];
        O_DATA_OE_N = I_USER_OE_N[7:0] | ~data_user;
        O_SERIAL_COMMAND_OUT = cmd_out;
        O_MEMORY_SELECT_LOW = sel_low;
        // chain enable released until done, then low or user I/O
        O_CHAIN_ENABLE = in_user && I_SHARED_PIN_USER && I_USER_OUT[8];
        O_CHAIN_ENABLE_OE_N = in_user ? (I_SHARED_PIN_USER & I_USER_OE_N[8]) : 1'b1;
        O_USER_IN = {chain_s, data_s};
        O_CFG_BYTE = byte_out;
        O_CFG_BYTE_VALID = byte_valid;
        O_USER_MODE = in_user;
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence s_enter_cmd;
        state == cpc_pkg::ST_IDLE ##1 state == cpc_pkg::ST_COMMAND;
    endsequence
    sequence s_idle_blocked;
        state == cpc_pkg::ST_IDLE && ce_s && restart_s;
    endsequence

    property p_restart_reset;
        !restart_s |=> state == cpc_pkg::ST_RESET;
    endproperty
    a_restart_reset: assert property (p_restart_reset) else $error("restart ignored");
    property p_reset_tristate;
        state == cpc_pkg::ST_RESET |-> (&O_DATA_OE_N) && O_CONFIG_CLOCK_OE_N && O_CHAIN_ENABLE_OE_N;
    endproperty
    a_reset_tristate: assert property (p_reset_tristate) else $error("pin driven in reset");
    property p_ce_block;
        state == cpc_pkg::ST_LOAD && mode != cpc_pkg::MD_AS && ce_s |=> !O_CFG_BYTE_VALID;
    endproperty
    a_ce_block: assert property (p_ce_block) else $error("data taken with enable high");
    property p_idle_hold;
        s_idle_blocked |=> state == cpc_pkg::ST_IDLE;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("left idle while disabled");
    property p_chain_released;
        state != cpc_pkg::ST_USER |-> O_CHAIN_ENABLE_OE_N;
    endproperty
    a_chain_released: assert property (p_chain_released) else $error("chain enable early");
    property p_chain_low;
        in_user && !I_SHARED_PIN_USER |-> !O_CHAIN_ENABLE_OE_N && !O_CHAIN_ENABLE;
    endproperty
    a_chain_low: assert property (p_chain_low) else $error("chain enable not low");
    property p_cmd_first;
        s_enter_cmd |-> O_SERIAL_COMMAND_OUT == cpc_pkg::MEM_READ_OPCODE[7] && !O_MEMORY_SELECT_LOW;
    endproperty
    a_cmd_first: assert property (p_cmd_first) else $error("bad command start");
    property p_select;
        as_active |-> !O_MEMORY_SELECT_LOW && !O_CONFIG_CLOCK_OE_N;
    endproperty
    a_select: assert property (p_select) else $error("memory not selected");
    property p_clk_toggle;
        state == cpc_pkg::ST_COMMAND && tick |=> O_CONFIG_CLOCK != $past(O_CONFIG_CLOCK);
    endproperty
    a_clk_toggle: assert property (p_clk_toggle) else $error("clock not toggled");
    property p_fpp_byte;
        state == cpc_pkg::ST_LOAD && mode == cpc_pkg::MD_FPP && !I_LOAD_DONE && restart_s
            && pas_rise && !ce_s |=> O_CFG_BYTE_VALID && O_CFG_BYTE == $past(data_s);
    endproperty
    a_fpp_byte: assert property (p_fpp_byte) else $error("byte not captured");
    property p_ps_byte;
        state == cpc_pkg::ST_LOAD && mode == cpc_pkg::MD_PS && !I_LOAD_DONE && restart_s
            && pas_rise && !ce_s && bit_cnt == 3'h7 |=> O_CFG_BYTE_VALID;
    endproperty
    a_ps_byte: assert property (p_ps_byte) else $error("serial byte lost");
    property p_user_clock;
        in_user && mode == cpc_pkg::MD_AS |-> !O_CONFIG_CLOCK && !O_CONFIG_CLOCK_OE_N;
    endproperty
    a_user_clock: assert property (p_user_clock) else $error("clock not inactive");
    property p_upper_tristate;
        !in_user |-> &O_DATA_OE_N[7:1];
    endproperty
    a_upper_tristate: assert property (p_upper_tristate) else $error("upper pin driven");
    property p_serial_config_bit_dedicated;
        !VARIANT_B |-> O_DATA_OE_N[0];
    endproperty
    a_serial_config_bit_dedicated: assert property (p_serial_config_bit_dedicated) else $error("serial_config_bit driven");
    property p_scheme_as;
        state == cpc_pkg::ST_IDLE && !ce_s && restart_s && scheme_s == sel_as
            |=> state == cpc_pkg::ST_COMMAND;
    endproperty
    a_scheme_as: assert property (p_scheme_as) else $error("scheme not honoured");
endmodule : cpc_config_port

// ---- hw/cpc_pin_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cpc_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    initial begin
        if (WIDTH < 1) $error("cpc_pin_sync: WIDTH must be at least 1");
    end

    always_comb begin
        next_meta = i_async;
        next_sync = meta;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule : cpc_pin_sync

// ---- hw/cpc_pkg.sv ----
// Shared constants and types for the configuration-port pin logic
package cpc_pkg;
    // Scheme-select encodings
    localparam logic [3:0] SCHEME_FPP = 4'h0;
    localparam logic [3:0] SCHEME_PS = 4'h2;
    localparam logic [3:0] SCHEME_AS = 4'h3;
    // Serial memory read command and start address
    localparam logic [7:0] MEM_READ_OPCODE = 8'h03;
    localparam logic [23:0] MEM_START_ADDR = 24'h000000;
    localparam int CMD_BITS = 32;
    // Generated clock timing
    localparam int REF_PERIOD_NS = 20;
    localparam int AS_HALF_PERIOD_NS = 100;
    localparam int AS_HALF_CYCLES = (AS_HALF_PERIOD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    // Values after reset
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [2:0] BIT_CNT_RST = 3'h0;

    typedef enum logic [4:0] {
        ST_RESET = 5'b00001,
        ST_IDLE = 5'b00010,
        ST_COMMAND = 5'b00100,
        ST_LOAD = 5'b01000,
        ST_USER = 5'b10000
    } cpc_state_t;

    typedef enum logic [2:0] {
        MD_PS = 3'b001,
        MD_FPP = 3'b010,
        MD_AS = 3'b100
    } cpc_mode_t;
endpackage : cpc_pkg

// ---- tb/cpc_far_model.sv ----
// Far-side model: configuration host and serial configuration memory
`timescale 1ns/1ps
module cpc_far_model #(
    parameter logic [7:0] PAT = 8'h5a
) (
    input wire logic i_pin_clk,
    input wire logic i_sel_low,
    input wire logic i_cmd,
    output logic o_host_clk,
    output logic o_host_en,
    output logic [7:0] o_data
);
    logic [31:0] cmd;
    int n;
    int k;
    initial begin
        o_host_clk = 1'b0;
        o_host_en = 1'b1;
        o_data = 8'h00;
        cmd = 32'h0;
        n = 0;
        k = 0;
    end
    task automatic send(input logic [7:0] v);
        begin
            o_data = v;
            #80 o_host_clk = 1'b1;
            #80 o_host_clk = 1'b0;
            // Released lines show the inverse, not a stale match
            o_data = ~v;
            // Spacing so back-to-back units never share a time step
            #80;
        end
    endtask : send
    task automatic set_en(input logic e);
        begin
            o_host_en = e;
        end
    endtask : set_en
    always @(negedge i_sel_low) begin
        n = 0;
        k = 0;
    end
    always @(posedge i_pin_clk) begin
        if (!i_sel_low && n < 32) begin
            cmd = {cmd[30:0], i_cmd};
            n = n + 1;
        end
    end
    always @(negedge i_pin_clk) begin
        if (!i_sel_low && n == 32) begin
            o_data[0] = PAT[k % 8];
            k = k + 1;
        end
    end
    always @(posedge i_sel_low) begin
        o_data[0] = ~o_data[0];
    end
endmodule : cpc_far_model

// ---- tb/tb.sv ----
// Testbench for the configuration-port pin logic
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce_n = 1'b1;
    logic restart_n = 1'b0;
    logic [3:0] sel = cpc_pkg::SCHEME_FPP;
    logic shared = 1'b0;
    logic done = 1'b0;
    logic [8:0] uout = 9'h155;
    logic [8:0] uoe_n = 9'h1ff;
    logic cclk_o, cclk_oe_n, cmd_o, msel_n, chain_o, chain_oe_n, valid, umode;
    logic host_clk, host_en, cclk_pin, chain_pin;
    logic [7:0] dout, doe_n, cbyte, far_data, data_pin, last, doe_n_b;
    logic [8:0] uin;
    int fails = 0;
    int compares = 0;
    int nvalid = 0;
    always #10 clk = ~clk;
    // Pull-ups on clock and open-drain chain pin
    assign cclk_pin = !cclk_oe_n ? cclk_o : (host_en ? host_clk : 1'b1);
    assign chain_pin = !chain_oe_n ? chain_o : 1'b1;
    assign data_pin = (dout & ~doe_n) | (far_data & doe_n);
    cpc_config_port u_dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CHIP_ENABLE_LOW(ce_n),
        .I_CONFIG_RESTART_LOW(restart_n), .I_SCHEME_SELECT(sel), .I_SHARED_PIN_USER(shared),
        .I_LOAD_DONE(done), .I_CONFIG_CLOCK(cclk_pin), .O_CONFIG_CLOCK(cclk_o),
        .O_CONFIG_CLOCK_OE_N(cclk_oe_n), .I_DATA(data_pin), .O_DATA(dout),
        .O_DATA_OE_N(doe_n), .O_SERIAL_COMMAND_OUT(cmd_o), .O_MEMORY_SELECT_LOW(msel_n),
        .I_CHAIN_ENABLE(chain_pin), .O_CHAIN_ENABLE(chain_o),
        .O_CHAIN_ENABLE_OE_N(chain_oe_n), .I_USER_OUT(uout), .I_USER_OE_N(uoe_n),
        .O_USER_IN(uin), .O_CFG_BYTE(cbyte), .O_CFG_BYTE_VALID(valid), .O_USER_MODE(umode));
    // Second variant: serial data pin may become user I/O
    cpc_config_port #(.VARIANT_B(1'b1)) u_dut_b (.I_REF_CLK(clk), .I_RST_N(rst_n),
        .I_CHIP_ENABLE_LOW(ce_n), .I_CONFIG_RESTART_LOW(restart_n), .I_SCHEME_SELECT(sel),
        .I_SHARED_PIN_USER(shared), .I_LOAD_DONE(done), .I_CONFIG_CLOCK(cclk_pin),
        .O_CONFIG_CLOCK(), .O_CONFIG_CLOCK_OE_N(), .I_DATA(data_pin), .O_DATA(),
        .O_DATA_OE_N(doe_n_b), .O_SERIAL_COMMAND_OUT(), .O_MEMORY_SELECT_LOW(),
        .I_CHAIN_ENABLE(chain_pin), .O_CHAIN_ENABLE(), .O_CHAIN_ENABLE_OE_N(),
        .I_USER_OUT(uout), .I_USER_OE_N(uoe_n), .O_USER_IN(), .O_CFG_BYTE(),
        .O_CFG_BYTE_VALID(), .O_USER_MODE());
    cpc_far_model u_far (.i_pin_clk(cclk_pin), .i_sel_low(msel_n), .i_cmd(cmd_o),
        .o_host_clk(host_clk), .o_host_en(host_en), .o_data(far_data));
    always @(posedge clk) begin
        if (valid === 1'b1) begin
            nvalid++;
            last = cbyte;
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            compares++;
            if (seen !== exp) begin
                fails++;
                $display("BAD %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask : check
    task automatic end_sim;
        begin
            $display("Checks %0d mismatches %0d", compares, fails);
            if (fails == 0 && compares > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask : end_sim
    task automatic cyc(input int n);
        begin
            repeat (n) @(negedge clk);
        end
    endtask : cyc
    // Bounded wait; a missing byte shows in the count or byte check
    task automatic wait_valid(input int n);
        int t;
        begin
            t = 0;
            while (nvalid < n && t < 3000) begin
                @(negedge clk);
                t++;
            end
            cyc(2);
        end
    endtask : wait_valid
    task automatic restart(input logic [3:0] s);
        begin
            done = 1'b0;
            restart_n = 1'b0;
            sel = s;
            cyc(6);
            restart_n = 1'b1;
            cyc(6);
            nvalid = 0;
        end
    endtask : restart
    task automatic t_fpp;
        begin
            restart(cpc_pkg::SCHEME_FPP);
            ce_n = 1'b0;
            cyc(4);
            u_far.send(8'ha5);
            u_far.send(8'h3c);
            wait_valid(2);
            check("fpp_count", nvalid, 2);
            check("fpp_byte", last, 8'h3c);
            ce_n = 1'b1;
            cyc(4);
            u_far.send(8'h77);
            cyc(10);
            check("fpp_ce_high", nvalid, 2);
            ce_n = 1'b0;
            cyc(4);
            check("fpp_chain_rel", chain_pin, 1'b1);
            done = 1'b1;
            cyc(4);
            check("fpp_user", umode, 1'b1);
            check("fpp_chain_low", chain_pin, 1'b0);
            check("fpp_oe_kept", doe_n, 8'hff);
            shared = 1'b1;
            uoe_n = 9'h000;
            cyc(2);
            check("fpp_oe_user", doe_n, 8'h01);
            check("fpp_dout", dout, 8'h55);
            check("chain_user_oe", chain_oe_n, 1'b0);
            check("chain_user_val", chain_o, 1'b1);
            check("fpp_user_in", uin[8:1], 8'haa);
            u_far.send(8'h11);
            cyc(10);
            check("fpp_after_clk", nvalid, 2);
            restart_n = 1'b0;
            cyc(5);
            check("rst_user", umode, 1'b0);
            check("rst_oe", doe_n, 8'hff);
            check("rst_chain", chain_oe_n, 1'b1);
            shared = 1'b0;
            uoe_n = 9'h1ff;
        end
    endtask : t_fpp
    task automatic t_ps;
        logic [7:0] b;
        begin
            b = 8'h96;
            restart(cpc_pkg::SCHEME_PS);
            check("ps_upper_oe", doe_n, 8'hff);
            for (int i = 0; i < 7; i++) begin
                u_far.send({7'h00, b[i]});
            end
            cyc(8);
            check("ps_partial", nvalid, 0);
            u_far.send({7'h00, b[7]});
            wait_valid(1);
            check("ps_byte", last, 8'h96);
            done = 1'b1;
            shared = 1'b1;
            uout = 9'h0aa;
            uoe_n = 9'h100;
            cyc(4);
            check("ps_user_oe", doe_n, 8'h01);
            check("ps_user_oe_b", doe_n_b, 8'h00);
            check("ps_dout", dout, 8'haa);
            check("ps_user_in", uin[8:1], 8'hd5);
            shared = 1'b0;
            uout = 9'h155;
            uoe_n = 9'h1ff;
        end
    endtask : t_ps
    task automatic t_as;
        begin
            // Unknown scheme code: device stays idle
            restart(4'hf);
            u_far.send(8'h12);
            cyc(8);
            check("bad_scheme", nvalid, 0);
            check("bad_scheme_sel", msel_n, 1'b1);
            ce_n = 1'b1;
            restart(cpc_pkg::SCHEME_AS);
            u_far.set_en(1'b0);
            cyc(20);
            check("as_wait_ce", msel_n, 1'b1);
            ce_n = 1'b0;
            cyc(5);
            check("as_select", msel_n, 1'b0);
            check("as_clk_oe", cclk_oe_n, 1'b0);
            wait_valid(1);
            check("as_cmd", u_far.cmd, 32'h03000000);
            check("as_byte", last, 8'h5a);
            done = 1'b1;
            cyc(4);
            check("as_deselect", msel_n, 1'b1);
            check("as_clk_park", cclk_pin, 1'b0);
            u_far.set_en(1'b1);
        end
    endtask : t_as
    initial begin
        #400000;
        fails++;
        end_sim();
    end
    initial begin
        cyc(10);
        rst_n = 1'b1;
        cyc(2);
        check("rst_data_oe", doe_n, 8'hff);
        check("rst_select", msel_n, 1'b1);
        check("rst_chain_rel", chain_pin, 1'b1);
        t_fpp();
        t_ps();
        t_as();
        end_sim();
    end
endmodule : tb
